//--- rtl/wii_interlock.sv
// Weld initiation and interlock front end with APB register access.
`include "wii_defs.svh"

// What this block does
// - Main pilot runs the displayed schedule
// - Second pilot starts schedule 20
// - Third pilot starts schedule 40
// - External select: pilots two/three point schedule
// - Single-stage start latched until sequence ends
// - Repeat single-stage: restart while contact closed
// - First stage energises valves, no sequence
// - Second stage latched, blocks new starts
// - Repeat two-stage: restart while either closed
// - Pressure open: wait, flash clamp indicator
// - Long pressure wait flashes error, continues
// - Zero weld time skips pressure check
// - Emergency stop halts all, flashes indication
// - No automatic restart after emergency stop
// - Fire only while weld enable closed
// - Any open in stop chain stops
// - Coolant open refuses starts, shows error
module wii_interlock import wii_pkg::*; #(
	parameter int DEBOUNCE_CYCLES = `WII_CLK_HZ / 1000000 * `WII_DEBOUNCE_US,
	parameter int FLASH_CYCLES = `WII_CLK_HZ / 1000 * `WII_FLASH_HALF_MS,
	parameter int PRESS_TIMEOUT_CYCLES = `WII_CLK_HZ / 1000 * `WII_PRESS_TIMEOUT_MS
) (
	input wire logic REF_CLK, // System clock, 200 MHz.
	input wire logic RST, // Synchronous reset, active high.
	input wire logic PSEL, // APB select.
	input wire logic PENABLE, // APB access phase.
	input wire logic PWRITE, // APB write.
	input wire logic [11:0] PADDR, // APB byte address.
	input wire logic [31:0] PWDATA, // APB write data.
	output logic [31:0] PRDATA, // APB read data.
	output logic PREADY, // APB ready.
	output logic PSLVERR, // APB error on unmapped address.
	input wire logic FIRST_STAGE_PILOT_IN_N, // First stage, low when closed.
	input wire logic MAIN_PILOT_IN_N, // Main pilot, low when closed.
	input wire logic SECOND_PILOT_OR_SELECT_LSB_N, // Second pilot or pointer bit 0.
	input wire logic THIRD_PILOT_OR_SELECT_MSB_N, // Third pilot or pointer bit 1.
	input wire logic PRESSURE_OK_IN_N, // Pressure reached, low when closed.
	input wire logic EMERGENCY_STOP_CHAIN_IN_N, // Stop chain, low while intact.
	input wire logic WELD_ENABLE_IN_N, // Weld enable, low when closed.
	input wire logic COOLANT_FLOW_IN_N, // Coolant flowing, low when closed.
	output logic VALVE_ON, // Schedule valves energised.
	output logic WELD_FIRE, // Firing pulses allowed.
	output logic CLAMP_LED, // Clamp interval indicator, flashes on pressure wait.
	output logic ESTOP_FLASH, // Emergency stop indication on both displays.
	output logic PRESSURE_ERR_FLASH, // Pressure error code flashing.
	output logic COOLANT_ERR, // Coolant error code shown.
	output logic [7:0] ACTIVE_SCHED, // Schedule number being run.
	output logic BUSY, // Sequence in progress.
	output logic IRQ // Interrupt, high while unmasked event pending.
);

	// ==========================================================================
	// Input conditioning
	logic [7:0] closed;
	logic fs1_c, main_c, sec_c, third_c, press_c, chain_c, weld_en_c, flow_c;

	// Every contact is debounced before the sequencer sees it.
	wii_debounce #(.WIDTH(8), .COUNT(DEBOUNCE_CYCLES)) u_debounce (
		.clk(REF_CLK),
		.rst(RST),
		.raw_n({COOLANT_FLOW_IN_N, WELD_ENABLE_IN_N, EMERGENCY_STOP_CHAIN_IN_N,
			PRESSURE_OK_IN_N, THIRD_PILOT_OR_SELECT_MSB_N, SECOND_PILOT_OR_SELECT_LSB_N,
			MAIN_PILOT_IN_N, FIRST_STAGE_PILOT_IN_N}),
		.closed(closed)
	);

	assign {flow_c, weld_en_c, chain_c, press_c, third_c, sec_c, main_c, fs1_c} = closed;

	// ==========================================================================
	// Register state
	logic [31:0] ctrl_reg, ctrl_next, times_reg, times_next;
	logic [`WII_EV_WIDTH-1:0] int_stat_reg, int_stat_next, int_mask_reg, int_mask_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next, pslverr_reg, pslverr_next, irq_reg, irq_next;
	logic [`WII_EV_WIDTH-1:0] events;
	logic [31:0] status_word;

	// ==========================================================================
	// Sequencer state
	wii_seq_type state_reg, state_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [31:0] pwait_reg, pwait_next;
	logic [31:0] flash_cnt_reg, flash_cnt_next;
	logic flash_reg, flash_next, armed_reg, armed_next, perr_reg, perr_next;
	logic [7:0] sched_reg, sched_next;
	logic valve_reg, valve_next, fire_reg, fire_next, clamp_led_reg, clamp_led_next;
	logic estop_flash_reg, estop_flash_next, perr_flash_reg, perr_flash_next;
	logic coolant_reg, coolant_next, busy_reg, busy_next;

	// Configuration fields.
	logic [1:0] sel_mode;
	logic repeat_mode, two_stage;
	logic [7:0] disp_sched, pre_weld_clamp_interval_t, weld_t, hold_t;
	logic ext_sel, estop, start_any, start_ok;
	logic [7:0] start_sched;
	logic repeat_hold;

	assign sel_mode = ctrl_reg[`WII_CTRL_SEL_LSB +: 2];
	assign repeat_mode = ctrl_reg[`WII_CTRL_REPEAT_BIT];
	assign two_stage = ctrl_reg[`WII_CTRL_TWO_STAGE_BIT];
	assign disp_sched = ctrl_reg[`WII_CTRL_DISP_LSB +: 8];
	assign pre_weld_clamp_interval_t = times_reg[7:0];
	assign weld_t = times_reg[15:8];
	assign hold_t = times_reg[23:16];
	assign ext_sel = (sel_mode == `WII_SEL_EXTERNAL);
	// A break anywhere in the series chain reads as open.
	assign estop = !chain_c;

	// ==========================================================================
	// Start decode: which input started and which schedule it selects
	always_comb begin
		start_sched = disp_sched;
		if (ext_sel) begin
			start_any = main_c;
			start_sched = `WII_SCHED_EXT_BASE + {6'h00, third_c, sec_c};
		end else begin
			start_any = main_c | sec_c | third_c;
			if (!main_c && sec_c) begin
				start_sched = `WII_SCHED_SECOND;
			end else if (!main_c && third_c) begin
				start_sched = `WII_SCHED_THIRD;
			end
		end
		// Starts need a fresh closure, a running coolant flow and an intact chain.
		start_ok = start_any && armed_reg && flow_c && !estop;
		// Repeat keeps going on the start contact, or on either stage when two-stage.
		repeat_hold = repeat_mode && flow_c && (start_any || (two_stage && fs1_c));
	end

	// ==========================================================================
	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		pwait_next = 32'h0000_0000;
		perr_next = perr_reg;
		sched_next = sched_reg;
		armed_next = armed_reg;
		events = '0;
		flash_cnt_next = flash_cnt_reg + 32'h0000_0001;
		flash_next = flash_reg;
		if (flash_cnt_reg >= 32'(FLASH_CYCLES - 1)) begin
			flash_cnt_next = 32'h0000_0000;
			flash_next = !flash_reg;
		end
		// The latch is rearmed only once every pilot is released.
		if (!start_any && !fs1_c) begin
			armed_next = 1'b1;
		end
		if (state_reg == SEQ_IDLE && start_any && armed_reg && !flow_c) begin
			events[`WII_EV_REFUSED] = 1'b1;
		end
		if (!flow_c) begin
			events[`WII_EV_COOLANT] = 1'b1;
		end
		if (estop) begin
			// Stop wins over everything; a new closure is needed afterwards.
			if (state_reg != SEQ_IDLE) begin
				events[`WII_EV_ESTOP] = 1'b1;
			end
			state_next = SEQ_IDLE;
			armed_next = 1'b0;
			perr_next = 1'b0;
		end else begin
			case (state_reg)
				SEQ_IDLE: begin
					if (start_ok) begin
						state_next = SEQ_CLAMP;
						cnt_next = pre_weld_clamp_interval_t;
						sched_next = start_sched;
						armed_next = 1'b0;
					end
				end
				SEQ_CLAMP: begin
					if (cnt_reg == 8'h00) begin
						if (weld_t == 8'h00 || press_c) begin
							state_next = SEQ_WELD;
							cnt_next = weld_t;
						end else begin
							state_next = SEQ_PRESS_WAIT;
						end
					end else begin
						cnt_next = cnt_reg - 8'h01;
					end
				end
				SEQ_PRESS_WAIT: begin
					pwait_next = pwait_reg + 32'h0000_0001;
					if (press_c) begin
						state_next = SEQ_WELD;
						cnt_next = weld_t;
						pwait_next = 32'h0000_0000;
						perr_next = 1'b0;
					end else if (pwait_reg == 32'(PRESS_TIMEOUT_CYCLES - 1)) begin
						// The error is shown, but the sequence keeps waiting.
						perr_next = 1'b1;
						events[`WII_EV_PRESS_TO] = 1'b1;
					end
				end
				SEQ_WELD: begin
					if (cnt_reg == 8'h00) begin
						state_next = SEQ_HOLD;
						cnt_next = hold_t;
					end else begin
						cnt_next = cnt_reg - 8'h01;
					end
				end
				SEQ_HOLD: begin
					if (cnt_reg == 8'h00) begin
						events[`WII_EV_DONE] = 1'b1;
						if (repeat_hold) begin
							state_next = SEQ_CLAMP;
							cnt_next = pre_weld_clamp_interval_t;
						end else begin
							state_next = SEQ_IDLE;
						end
					end else begin
						cnt_next = cnt_reg - 8'h01;
					end
				end
				default: begin
					state_next = SEQ_IDLE;
				end
			endcase
		end
	end

	// ==========================================================================
	// Output next values, all registered so the pins never glitch
	always_comb begin
		// Idle valves follow the first stage only in two-stage starting.
		valve_next = !estop && ((state_next != SEQ_IDLE) ||
			(two_stage && fs1_c));
		// With the enable contact open the sequence runs without current.
		fire_next = !estop && weld_en_c && (state_next == SEQ_WELD);
		clamp_led_next = (state_next == SEQ_CLAMP) ||
			((state_next == SEQ_PRESS_WAIT) && flash_next);
		estop_flash_next = estop && flash_next;
		perr_flash_next = perr_next && flash_next;
		coolant_next = !flow_c;
		busy_next = (state_next != SEQ_IDLE);
	end

	// Sequencer and output registers.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state_reg <= SEQ_IDLE;
			cnt_reg <= 8'h00;
			pwait_reg <= 32'h0000_0000;
			flash_cnt_reg <= 32'h0000_0000;
			flash_reg <= 1'b0;
			armed_reg <= 1'b0;
			perr_reg <= 1'b0;
			sched_reg <= 8'h00;
			valve_reg <= 1'b0;
			fire_reg <= 1'b0;
			clamp_led_reg <= 1'b0;
			estop_flash_reg <= 1'b0;
			perr_flash_reg <= 1'b0;
			coolant_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			pwait_reg <= pwait_next;
			flash_cnt_reg <= flash_cnt_next;
			flash_reg <= flash_next;
			armed_reg <= armed_next;
			perr_reg <= perr_next;
			sched_reg <= sched_next;
			valve_reg <= valve_next;
			fire_reg <= fire_next;
			clamp_led_reg <= clamp_led_next;
			estop_flash_reg <= estop_flash_next;
			perr_flash_reg <= perr_flash_next;
			coolant_reg <= coolant_next;
			busy_reg <= busy_next;
		end
	end

	// ==========================================================================
	// APB slave: one wait state, then the answer from flip-flops
	assign status_word = {8'h00, sched_reg, 8'h00, 1'b0, perr_reg, !flow_c, estop,
		armed_reg, 3'(state_reg)};

	always_comb begin
		ctrl_next = ctrl_reg;
		times_next = times_reg;
		int_mask_next = int_mask_reg;
		prdata_next = 32'h0000_0000;
		pslverr_next = 1'b0;
		pready_next = PSEL && PENABLE && !pready_reg;
		// Hardware sets win over a software clear in the same cycle.
		int_stat_next = int_stat_reg | events;
		if (pready_next) begin
			if (PADDR == `WII_CTRL_OFS) begin
				prdata_next = ctrl_reg;
			end else if (PADDR == `WII_TIMES_OFS) begin
				prdata_next = times_reg;
			end else if (PADDR == `WII_STATUS_OFS) begin
				prdata_next = status_word;
			end else if (PADDR == `WII_INT_STAT_OFS) begin
				prdata_next = {27'h0, int_stat_reg};
			end else if (PADDR == `WII_INT_MASK_OFS) begin
				prdata_next = {27'h0, int_mask_reg};
			end else begin
				pslverr_next = 1'b1;
			end
		end
		// Writes land at the completing edge only.
		if (PSEL && PENABLE && pready_reg && PWRITE) begin
			if (PADDR == `WII_CTRL_OFS) begin
				ctrl_next = PWDATA & 32'h0000_FF0F;
			end else if (PADDR == `WII_TIMES_OFS) begin
				times_next = {8'h00, PWDATA[23:0]};
			end else if (PADDR == `WII_INT_STAT_OFS) begin
				int_stat_next = (int_stat_reg & ~PWDATA[`WII_EV_WIDTH-1:0]) | events;
			end else if (PADDR == `WII_INT_MASK_OFS) begin
				int_mask_next = PWDATA[`WII_EV_WIDTH-1:0];
			end
		end
		irq_next = |(int_stat_next & int_mask_next);
	end

	// Register file flip-flops.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ctrl_reg <= `WII_CTRL_RESET;
			times_reg <= `WII_TIMES_RESET;
			int_stat_reg <= '0;
			int_mask_reg <= '0;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			times_reg <= times_next;
			int_stat_reg <= int_stat_next;
			int_mask_reg <= int_mask_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			irq_reg <= irq_next;
		end
	end

	// ==========================================================================
	// Port drive
	assign PRDATA = prdata_reg;
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign VALVE_ON = valve_reg;
	assign WELD_FIRE = fire_reg;
	assign CLAMP_LED = clamp_led_reg;
	assign ESTOP_FLASH = estop_flash_reg;
	assign PRESSURE_ERR_FLASH = perr_flash_reg;
	assign COOLANT_ERR = coolant_reg;
	assign ACTIVE_SCHED = sched_reg;
	assign BUSY = busy_reg;
	assign IRQ = irq_reg;

endmodule : wii_interlock

//--- rtl/wii_defs.svh
// Register offsets, field positions, reset values and timing figures of the weld interlock.
`ifndef WII_DEFS_SVH
`define WII_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define WII_CTRL_OFS 12'h000
`define WII_TIMES_OFS 12'h004
`define WII_STATUS_OFS 12'h008
`define WII_INT_STAT_OFS 12'h00C
`define WII_INT_MASK_OFS 12'h010

// ==========================================================================
// Control register fields and reset values
`define WII_CTRL_SEL_LSB 0
`define WII_CTRL_REPEAT_BIT 2
`define WII_CTRL_TWO_STAGE_BIT 3
`define WII_CTRL_DISP_LSB 8
`define WII_CTRL_RESET 32'h0000_0100
`define WII_TIMES_RESET 32'h0004_0404
`define WII_SEL_EXTERNAL 2'h1

// ==========================================================================
// Schedule numbers
`define WII_SCHED_SECOND 8'h14
`define WII_SCHED_THIRD 8'h28
`define WII_SCHED_EXT_BASE 8'h01

// ==========================================================================
// Interrupt event bits
`define WII_EV_DONE 0
`define WII_EV_ESTOP 1
`define WII_EV_PRESS_TO 2
`define WII_EV_COOLANT 3
`define WII_EV_REFUSED 4
`define WII_EV_WIDTH 5

// ==========================================================================
// Timing figures and clock rate
`define WII_CLK_HZ 200000000
`define WII_DEBOUNCE_US 1000
`define WII_FLASH_HALF_MS 250
`define WII_PRESS_TIMEOUT_MS 2000

`endif

//--- rtl/wii_pkg.sv
// Types shared by the weld initiation interlock design.
package wii_pkg;

	// ==========================================================================
	// Sequence states
	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_CLAMP,
		SEQ_PRESS_WAIT,
		SEQ_WELD,
		SEQ_HOLD
	} wii_seq_type;

endpackage : wii_pkg

//--- rtl/wii_debounce.sv
// Synchroniser and debouncer for the contact-closure inputs.
module wii_debounce #(
	parameter int WIDTH = 8,
	parameter int COUNT = 200000
) (
	input wire logic clk, // System clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [WIDTH-1:0] raw_n, // Contacts, low when shorted to common.
	output logic [WIDTH-1:0] closed // Debounced, high while contact closed.
);

	// ==========================================================================
	// Per-contact synchroniser and stability counter
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic sync1_reg;
			logic sync2_reg;
			logic out_reg;
			logic out_next;
			logic [31:0] cnt_reg;
			logic [31:0] cnt_next;

			// A new level is accepted only after it has held for COUNT cycles.
			always_comb begin
				out_next = out_reg;
				cnt_next = 32'h0000_0000;
				if (!sync2_reg != out_reg) begin
					if (cnt_reg >= 32'(COUNT - 1)) begin
						out_next = !sync2_reg;
					end else begin
						cnt_next = cnt_reg + 32'h0000_0001;
					end
				end
			end

			// The first stage feeds only the second stage.
			always_ff @(posedge clk) begin
				if (rst) begin
					sync1_reg <= 1'b1;
					sync2_reg <= 1'b1;
					out_reg <= 1'b0;
					cnt_reg <= 32'h0000_0000;
				end else begin
					sync1_reg <= raw_n[gi];
					sync2_reg <= sync1_reg;
					out_reg <= out_next;
					cnt_reg <= cnt_next;
				end
			end

			assign closed[gi] = out_reg;
		end
	endgenerate

endmodule : wii_debounce

//--- testbench/wii_contacts.sv
// Contact-closure model of the operator pilots and machine interlock switches.
// ============================================================
// Contact model
module wii_contacts (
	input wire logic [8:0] closed, // Contact states, high while the contact is closed.
	output logic [7:0] line_n // Terminal levels, low while shorted to common.
);
	timeunit 1ns;
	timeprecision 1ps;
	// A closed contact pulls its terminal to common; an open one is pulled up.
	assign line_n[4:0] = ~closed[4:0];
	// The stop chain is two normally closed contacts in series, so either one breaks it.
	assign line_n[5] = ~(closed[5] & closed[6]);
	// Weld enable and coolant flow contacts.
	assign line_n[7:6] = ~closed[8:7];
endmodule : wii_contacts

//--- testbench/wii_interlock_asserts.sv
// Concurrent checks on the ports of the weld initiation interlock.
// ============================================================
// Checker
module wii_interlock_asserts (
	input wire logic REF_CLK, // System clock.
	input wire logic RST, // Synchronous reset.
	input wire logic PSEL, // APB select.
	input wire logic PENABLE, // APB access phase.
	input wire logic [31:0] PRDATA, // APB read data.
	input wire logic PREADY, // APB ready.
	input wire logic PSLVERR, // APB error.
	input wire logic EMERGENCY_STOP_CHAIN_IN_N, // Stop chain.
	input wire logic WELD_ENABLE_IN_N, // Weld enable.
	input wire logic VALVE_ON, // Valves.
	input wire logic WELD_FIRE, // Firing.
	input wire logic CLAMP_LED, // Clamp indicator.
	input wire logic ESTOP_FLASH, // Stop indication.
	input wire logic PRESSURE_ERR_FLASH, // Pressure error.
	input wire logic [7:0] ACTIVE_SCHED, // Schedule.
	input wire logic BUSY // Sequence running.
);
	timeunit 1ns;
	timeprecision 1ps;
	// One clock domain, so one default clock and reset guard.
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	a_ready_wait: assert property ($rose(PENABLE) && PSEL |=> PREADY)
		else $error("ready not one cycle after access");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	a_error_ready: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	a_data_idle: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("read data outside answer");
	// Counts of 8 and 2 cover two sync stages plus a debounce of 4 cycles.
	a_chain_stops: assert property (EMERGENCY_STOP_CHAIN_IN_N [*8] |=> ##2 !BUSY && !VALVE_ON)
		else $error("open chain did not stop");
	a_stop_quiet: assert property (ESTOP_FLASH |-> !VALVE_ON && !WELD_FIRE && !BUSY)
		else $error("activity during stop");
	a_fire_enable: assert property (WELD_ENABLE_IN_N [*8] |=> ##2 !WELD_FIRE)
		else $error("fired with enable open");
	a_fire_busy: assert property (WELD_FIRE |-> BUSY && VALVE_ON)
		else $error("fired outside sequence");
	a_start_clamp: assert property ($rose(BUSY) |-> VALVE_ON && CLAMP_LED)
		else $error("start without clamp");
	a_busy_valve: assert property (BUSY |-> VALVE_ON)
		else $error("sequence without valves");
	a_sched_hold: assert property (BUSY && $past(BUSY) |-> $stable(ACTIVE_SCHED))
		else $error("schedule changed in sequence");
	a_perr_busy: assert property (PRESSURE_ERR_FLASH |-> BUSY)
		else $error("pressure error aborted");
endmodule : wii_interlock_asserts

bind wii_interlock wii_interlock_asserts u_chk (
	.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .EMERGENCY_STOP_CHAIN_IN_N(EMERGENCY_STOP_CHAIN_IN_N),
	.WELD_ENABLE_IN_N(WELD_ENABLE_IN_N), .VALVE_ON(VALVE_ON), .WELD_FIRE(WELD_FIRE),
	.CLAMP_LED(CLAMP_LED), .ESTOP_FLASH(ESTOP_FLASH), .PRESSURE_ERR_FLASH(PRESSURE_ERR_FLASH),
	.ACTIVE_SCHED(ACTIVE_SCHED), .BUSY(BUSY)
);

//--- testbench/wii_interlock_tb.sv
// Self-checking bench for the weld initiation interlock.
module wii_interlock_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [8:0] FS = 9'h001, MP = 9'h002, P2 = 9'h004, P3 = 9'h008;
	logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, er;
	logic valve_on, weld_fire, clamp_led, estop_flash, press_err, coolant_err, busy, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [8:0] cl, bs;
	logic [7:0] sched;
	logic [7:0] ln;
	logic [1:0] fl;
	int miscompares, n_checks;

	// ============================================================
	// Design, contacts and clock
	wii_interlock #(.DEBOUNCE_CYCLES(4), .FLASH_CYCLES(4), .PRESS_TIMEOUT_CYCLES(20)) DUT (
		.REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.FIRST_STAGE_PILOT_IN_N(ln[0]), .MAIN_PILOT_IN_N(ln[1]),
		.SECOND_PILOT_OR_SELECT_LSB_N(ln[2]), .THIRD_PILOT_OR_SELECT_MSB_N(ln[3]),
		.PRESSURE_OK_IN_N(ln[4]), .EMERGENCY_STOP_CHAIN_IN_N(ln[5]), .WELD_ENABLE_IN_N(ln[6]),
		.COOLANT_FLOW_IN_N(ln[7]), .VALVE_ON(valve_on), .WELD_FIRE(weld_fire),
		.CLAMP_LED(clamp_led), .ESTOP_FLASH(estop_flash), .PRESSURE_ERR_FLASH(press_err),
		.COOLANT_ERR(coolant_err), .ACTIVE_SCHED(sched), .BUSY(busy), .IRQ(irq)
	);
	wii_contacts u_con (.closed(cl), .line_n(ln));
	// Free-running 200 MHz clock.
	initial begin
		ref_clk = 1'h0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ============================================================
	// Tasks
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask : chk
	function automatic logic sig(input int k);
		case (k)
			0: return busy;
			1: return weld_fire;
			2: return press_err;
			3: return clamp_led;
			default: return estop_flash;
		endcase
	endfunction : sig
	// Bounded wait for a level; running out of cycles ends the run as a failure.
	task automatic wt(input int k, input logic v);
		int i;
		for (i = 0; i < 300; i++) begin
			@(posedge ref_clk);
			if (sig(k) === v) break;
		end
		if (i == 300) begin
			miscompares++;
			$display("mismatch wait %0d exp %h got timeout", k, v);
			report_and_stop;
		end
	endtask : wt
	// Sees whether an output shows both levels, which a flashing output must.
	task automatic seen(input int k, output logic [1:0] r);
		r = 2'h0;
		repeat (10) begin
			@(posedge ref_clk);
			if (sig(k) === 1'h1) r[1] = 1'h1;
			if (sig(k) === 1'h0) r[0] = 1'h1;
		end
	endtask : seen
	// One APB transfer; the request holds until ready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (pready === 1'h1) break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (i == 50) begin
			miscompares++;
			$display("mismatch ready exp 1 got timeout");
			report_and_stop;
		end
	endtask : apb
	task automatic setc(input logic [8:0] v);
		@(posedge ref_clk);
		cl <= v;
	endtask : setc
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	// Pilot opens as soon as the sequence starts; 4+4+4 interval cycles follow.
	task automatic run(input logic [8:0] p, input logic [7:0] s, input logic f);
		int n;
		logic fs;
		n = 2;
		fs = 1'h0;
		setc(bs | p);
		wt(0, 1'h1);
		setc(bs);
		chk("schedule", {24'h0, s}, {24'h0, sched});
		while (n < 300) begin
			@(posedge ref_clk);
			if (weld_fire === 1'h1) fs = 1'h1;
			if (busy !== 1'h1) break;
			n++;
		end
		chk("busy cycles", 32'hC, n);
		chk("fired", {31'h0, f}, {31'h0, fs});
	endtask : run
	// A completion must still come after the first while contacts h stay closed.
	task automatic rep(input logic [8:0] s, input logic [8:0] h);
		setc(bs | s);
		wt(0, 1'h1);
		setc(bs | h);
		cyc(30);
		apb(1'h1, 12'h00C, 32'h1);
		cyc(20);
		apb(1'h0, 12'h00C, 32'h0);
		chk("repeat", 32'h1, {31'h0, rd[0]});
		setc(bs);
		cyc(40);
		chk("repeat stop", 32'h0, {31'h0, busy});
	endtask : rep

	// ============================================================
	// Test sequence
	initial begin
		logic [8:0] pl[3];
		logic [7:0] sc[3];
		pl = '{MP, P2, P3};
		sc = '{8'h07, 8'h14, 8'h28};
		rst = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		bs = 9'h1F0;
		cl = 9'h1F0;
		miscompares = 0;
		n_checks = 0;
		repeat (12) @(posedge ref_clk);
		rst <= 1'h0;
		cyc(20);
		apb(1'h0, 12'h000, 32'h0);
		chk("ctrl reset", 32'h100, rd);
		apb(1'h0, 12'h004, 32'h0);
		chk("times reset", 32'h40404, rd);
		apb(1'h0, 12'h008, 32'h0);
		chk("status idle", 32'h8, rd);
		apb(1'h0, 12'hFFC, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		apb(1'h1, 12'h000, 32'hFFFFFFFF);
		apb(1'h0, 12'h000, 32'h0);
		chk("ctrl bits", 32'hFF0F, rd);
		apb(1'h1, 12'h004, 32'h30303);
		apb(1'h1, 12'h00C, 32'h1F);
		apb(1'h1, 12'h010, 32'h1);
		apb(1'h1, 12'h000, 32'h700);
		$display("end of test registers");
		for (int i = 0; i < 3; i++) begin
			run(pl[i], sc[i], 1'h1);
			cyc(2);
			chk("irq", 32'h1, {31'h0, irq});
			apb(1'h1, 12'h00C, 32'h1);
			cyc(2);
			chk("irq clear", 32'h0, {31'h0, irq});
		end
		apb(1'h1, 12'h010, 32'h0);
		run(MP, 8'h07, 1'h1);
		cyc(2);
		chk("irq masked", 32'h0, {31'h0, irq});
		$display("end of test pilots");
		apb(1'h1, 12'h000, 32'h701);
		for (int p = 0; p < 4; p++) begin
			setc(bs | (9'(p) << 2));
			cyc(12);
			run(MP | (9'(p) << 2), 8'(p + 1), 1'h1);
		end
		apb(1'h1, 12'h000, 32'h708);
		setc(bs | FS);
		cyc(12);
		chk("first stage", 32'h2, {30'h0, valve_on, busy});
		run(FS | MP, 8'h07, 1'h1);
		apb(1'h1, 12'h000, 32'h704);
		rep(MP, MP);
		apb(1'h1, 12'h000, 32'h70C);
		rep(MP | FS, FS);
		$display("end of test starting modes");
		apb(1'h1, 12'h000, 32'h700);
		bs = 9'h1E0;
		setc(bs | MP);
		wt(0, 1'h1);
		setc(bs);
		cyc(8);
		seen(3, fl);
		chk("clamp flash", 32'h3, {30'h0, fl});
		chk("pressure held", 32'h2, {30'h0, busy, weld_fire});
		wt(2, 1'h1);
		chk("no abort", 32'h1, {31'h0, busy});
		setc(9'h1F0);
		wt(1, 1'h1);
		wt(0, 1'h0);
		apb(1'h1, 12'h004, 32'h30003);
		setc(bs | MP);
		wt(0, 1'h1);
		setc(bs);
		wt(0, 1'h0);
		apb(1'h1, 12'h004, 32'h30303);
		bs = 9'h170;
		setc(bs);
		cyc(12);
		run(MP, 8'h07, 1'h0);
		bs = 9'h1F0;
		$display("end of test pressure and enable");
		setc(bs | MP);
		wt(0, 1'h1);
		setc(9'h1B2);
		wt(0, 1'h0);
		seen(4, fl);
		chk("stop flash", 32'h3, {30'h0, fl});
		chk("stop quiet", 32'h0, {30'h0, valve_on, weld_fire});
		setc(bs | MP);
		cyc(30);
		chk("no restart", 32'h0, {31'h0, busy});
		apb(1'h0, 12'h00C, 32'h0);
		chk("stop event", 32'h2, rd & 32'h2);
		setc(bs);
		cyc(10);
		run(MP, 8'h07, 1'h1);
		setc(9'h0F2);
		cyc(15);
		chk("coolant", 32'h2, {30'h0, coolant_err, busy});
		setc(bs);
		cyc(12);
		apb(1'h0, 12'h00C, 32'h0);
		chk("refused", 32'h18, rd & 32'h18);
		$display("end of test stop and coolant");
		report_and_stop;
	end
endmodule : wii_interlock_tb
